//--- bench/board_far_side.sv
// far side of the board pins: usb power switch and transceiver bits
// assumes pins are registered levels from the register block
`timescale 1ns/1ns
module board_far_side
  import board_ctrl_pkg::*;
(
  // board pins
  input wire video_pins_t video_pins,
  input wire eth_pins_t eth_pins,
  // observed far-side state
  output logic vbus_5v,
  output logic [2:0] xcvr_bits
);
  // ------------------------------------------------------------
  // switch and transceiver
  // ------------------------------------------------------------
  always_comb begin
    vbus_5v = video_pins.usb_bus_power_on;
    // a held transceiver forgets its forced bits
    if (!eth_pins.fast_eth_xcvr_reset_n) begin
      xcvr_bits = 3'h0;
    end else begin
      // speed 0.13, duplex 0.8, link test 19.8; same pins with autoneg
      xcvr_bits = {eth_pins.fast_eth_speed_100,
                   eth_pins.fast_eth_full_duplex,
                   eth_pins.fast_eth_config_one};
    end
  end
endmodule : board_far_side

//--- bench/tb_top.sv
// bench for board control register four: board kinds against field values
// assumes zero wait states, OKAY only, registers at the package offsets
`timescale 1ns/1ns
module tb_top
  import board_ctrl_pkg::*;
;
  logic clk;
  logic resetn;
  ahb_req_t req;
  ahb_rsp_t rsp;
  video_pins_t vp;
  eth_pins_t ep;
  logic vbus;
  logic [2:0] xb;
  logic [31:0] rd;
  logic [31:0] rd_q;
  int fails;
  int n_checks;
  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] fld;
    logic [3:0] vid;
    logic [3:0] eth;
  } row_t;
  // led row: software lights it only with the port running; clock row: port set
  row_t rows [8] = '{'{2'h1, 6'h00, 4'hC, 4'h0},
                     '{2'h1, 6'h3F, 4'h3, 4'h0},
                     '{2'h1, 6'h2A, 4'h1, 4'h0},
                     '{2'h2, 6'h3F, 4'h0, 4'hF},
                     '{2'h2, 6'h2A, 4'h0, 4'h5},
                     '{2'h2, 6'h00, 4'h0, 4'h0},
                     '{2'h0, 6'h15, 4'h0, 4'h0},
                     '{2'h3, 6'h3F, 4'h0, 4'h0}};

  board_control_four board_control_four_i (.clk(clk), .resetn(resetn), .ahb_req(req),
    .ahb_rsp(rsp), .video_pins(vp), .eth_pins(ep));
  board_far_side board_far_side_i (.video_pins(vp), .eth_pins(ep), .vbus_5v(vbus),
    .xcvr_bits(xb));

  // ------------------------------------------------------------
  // clock and bus helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // read data as it stood before the edge that ends the data phase
  always @(posedge clk) rd_q <= rsp.hrdata;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 20);
    if (rsp.hreadyout !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask : wait_ready

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    req.haddr <= {24'h0, a};
    req.htrans <= 2'h2;
    req.hwrite <= w;
    wait_ready();
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    wait_ready();
    #1 rd = rd_q;
  endtask : xfer

  // ------------------------------------------------------------
  // table, then reset and odd cases
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    req = '0;
    req.hsize = 3'h2;
    req.hsel = 1'b1;
    req.hready = 1'b1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    xfer(1'b0, board_control_four_off, 32'h0);
    check(rd, 32'h760);
    foreach (rows[i]) begin
      xfer(1'b1, board_mode_off, {30'h0, rows[i].kind});
      xfer(1'b1, board_control_four_off, {21'h1FFFFF, rows[i].fld, 5'h1F});
      xfer(1'b0, board_control_four_off, 32'h0);
      check(rd, {21'h0, rows[i].fld, 5'h0});
      check({27'h0, vbus, vp}, {27'h0, rows[i].vid[3], rows[i].vid});
      check({28'h0, ep[4:1]}, {28'h0, rows[i].eth});
      check({29'h0, xb}, {29'h0, rows[i].eth[3:1] & {3{rows[i].eth[0]}}});
    end
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    xfer(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, board_mode_off, 32'h0);
    check(rd, 32'h3);
    xfer(1'b1, board_mode_off, 32'h2);
    xfer(1'b1, board_control_four_off, 32'h0);
    // speed field rising restarts negotiation for exactly one cycle
    xfer(1'b1, board_control_four_off, 32'h7E0);
    @(posedge clk);
    #1 check({31'h0, ep.autoneg_restart}, 32'h1);
    @(posedge clk);
    #1 check({27'h0, ep}, 32'h1E);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check({23'h0, vp, ep}, 32'h0);
    check(rsp.hrdata, 32'h0);
    resetn <= 1'b1;
    @(posedge clk);
    xfer(1'b0, board_control_four_off, 32'h0);
    check(rd, 32'h760);
    xfer(1'b0, board_mode_off, 32'h0);
    check(rd, 32'h0);
    finish_test();
  end
endmodule : tb_top

//--- rtl/board_control_four.sv
// AHB-Lite slave holding board control register four, fields 5 to 10
// assumes one clock, asynchronous active-low reset, single word transfers
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns

module board_control_four
  import board_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire ahb_req_t ahb_req,
  output ahb_rsp_t ahb_rsp,
  // board pins
  output video_pins_t video_pins,
  output eth_pins_t eth_pins
);

  typedef struct packed {
    logic [fld_hi:fld_lo] fields;
    board_kind_t kind;
    logic wr_pend;
    logic [7:0] wr_addr;
    ahb_rsp_t rsp;
  } reg_state_t;

  reg_state_t s_q;
  reg_state_t s_d;
  logic take;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // zero wait states: reads answer in the data phase right after the address
  assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

  always_comb begin
    s_d = s_q;
    s_d.rsp.hreadyout = 1'b1;
    s_d.rsp.hresp = 1'b0;
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == board_control_four_off) begin
        s_d.fields = ahb_req.hwdata[fld_hi:fld_lo];
      end
      if (s_q.wr_addr == board_mode_off) begin
        s_d.kind = board_kind_t'(ahb_req.hwdata[1:0]);
      end
    end
    if (take) begin
      s_d.wr_pend = ahb_req.hwrite;
      s_d.wr_addr = ahb_req.haddr[7:0];
      s_d.rsp.hrdata = 32'h0000_0000;
      if (ahb_req.haddr[7:0] == board_control_four_off) begin
        s_d.rsp.hrdata[fld_hi:fld_lo] = s_d.fields;
      end
      if (ahb_req.haddr[7:0] == board_mode_off) begin
        s_d.rsp.hrdata[1:0] = s_d.kind;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.fields <= board_control_four_rst;
      s_q.kind <= board_none;
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= 8'h00;
      s_q.rsp <= '{32'h0000_0000, 1'b1, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ahb_rsp = s_q.rsp;

  // ----------------------------------------------------------------
  // pin mapping
  // ----------------------------------------------------------------
  board_pin_map u_map (
    .clk(clk),
    .resetn(resetn),
    .fields(s_q.fields),
    .kind(s_q.kind),
    .video_pins(video_pins),
    .eth_pins(eth_pins)
  );

  // ----------------------------------------------------------------
  // bus checks
  // ----------------------------------------------------------------
  chk_write_store: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.wr_pend && s_q.wr_addr == board_control_four_off)
      |=> s_q.fields == $past(ahb_req.hwdata[fld_hi:fld_lo]))
    else $error("write not stored");
  chk_always_ready: assert property (@(posedge clk) disable iff (!resetn)
    ahb_rsp.hreadyout && !ahb_rsp.hresp)
    else $error("bus stalled");

  // reads: zero wait states, so data lands in the very next cycle
  chk_read_fields: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !ahb_req.hwrite &&
      ahb_req.haddr[7:0] == board_control_four_off)
    |=> (ahb_rsp.hrdata[fld_hi:fld_lo] == s_q.fields)
  ) else $error("read data misses stored fields");

  chk_read_pad: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !ahb_req.hwrite &&
      ahb_req.haddr[7:0] == board_control_four_off)
    |=> (ahb_rsp.hrdata[31:fld_hi+1] == '0 && ahb_rsp.hrdata[fld_lo-1:0] == '0)
  ) else $error("unused register bits not zero");

  chk_read_mode: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !ahb_req.hwrite &&
      ahb_req.haddr[7:0] == board_mode_off)
    |=> (ahb_rsp.hrdata[1:0] == s_q.kind)
  ) else $error("board kind read wrong");

  chk_read_mode_pad: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !ahb_req.hwrite &&
      ahb_req.haddr[7:0] == board_mode_off)
    |=> (ahb_rsp.hrdata[31:2] == '0)
  ) else $error("board kind upper bits not zero");

  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !ahb_req.hwrite &&
      ahb_req.haddr[7:0] != board_control_four_off &&
      ahb_req.haddr[7:0] != board_mode_off)
    |=> (ahb_rsp.hrdata == '0)
  ) else $error("unmapped read not zero");

  chk_rdata_stands: assert property (
    @(posedge clk) disable iff (!resetn)
    !take
    |=> $stable(ahb_rsp.hrdata)
  ) else $error("read data moved without a transfer");

  chk_write_flag: assert property (
    @(posedge clk) disable iff (!resetn)
    take
    |=> (s_q.wr_pend == $past(ahb_req.hwrite))
  ) else $error("write phase not captured");

  chk_write_addr: assert property (
    @(posedge clk) disable iff (!resetn)
    take
    |=> (s_q.wr_addr == $past(ahb_req.haddr[7:0]))
  ) else $error("write address not captured");

  chk_addr_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !take
    |=> $stable(s_q.wr_addr)
  ) else $error("write address moved");

  chk_idle_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    !take
    |=> !s_q.wr_pend
  ) else $error("write pending without transfer");

  chk_read_no_store: assert property (
    @(posedge clk) disable iff (!resetn)
    (take && !ahb_req.hwrite)
    |=> !s_q.wr_pend
  ) else $error("read marked as write");

  chk_fields_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(s_q.wr_pend && s_q.wr_addr == board_control_four_off)
    |=> $stable(s_q.fields)
  ) else $error("fields moved without a write");

  chk_spare_store: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.wr_pend && s_q.wr_addr == board_control_four_off)
    |=> (s_q.fields[fld_spare] == $past(ahb_req.hwdata[fld_spare]))
  ) else $error("spare field not stored");

  chk_kind_store: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.wr_pend && s_q.wr_addr == board_mode_off)
    |=> (s_q.kind == $past(ahb_req.hwdata[1:0]))
  ) else $error("board kind not stored");

  chk_kind_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    !(s_q.wr_pend && s_q.wr_addr == board_mode_off)
    |=> $stable(s_q.kind)
  ) else $error("board kind moved without a write");

  chk_unmapped_write: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.wr_pend && s_q.wr_addr != board_control_four_off &&
      s_q.wr_addr != board_mode_off)
    |=> ($stable(s_q.fields) && $stable(s_q.kind))
  ) else $error("unmapped write changed state");

  // ----------------------------------------------------------------
  // pin checks
  // ----------------------------------------------------------------
  // pins lag the stored fields by one register
  chk_speed_pin: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth)
    |=> (eth_pins.fast_eth_speed_100 == $past(s_q.fields[fld_speed]))
  ) else $error("speed pin wrong");

  chk_adv_duplex: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && !s_q.fields[fld_pwr_duplex])
    |=> !eth_pins.fast_eth_full_duplex
  ) else $error("duplex advertised while off");

  chk_duplex_full: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && s_q.fields[fld_pwr_duplex])
    |=> eth_pins.fast_eth_full_duplex
  ) else $error("full duplex not driven");

  chk_adv_speed: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && s_q.fields[fld_clk_cfg])
    |=> eth_pins.fast_eth_config_one
  ) else $error("speed advertisement pin low");

  chk_link_test: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && !s_q.fields[fld_clk_cfg])
    |=> !eth_pins.fast_eth_config_one
  ) else $error("link test left disabled");

  chk_restart_rise: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && s_q.fields[fld_speed] &&
      !$past(s_q.fields[fld_speed]))
    |=> eth_pins.autoneg_restart
  ) else $error("negotiation restart missing");

  chk_restart_pulse: assert property (
    @(posedge clk) disable iff (!resetn)
    eth_pins.autoneg_restart
    |=> !eth_pins.autoneg_restart
  ) else $error("negotiation restart longer than a cycle");

  chk_restart_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    !s_q.fields[fld_speed]
    |=> !eth_pins.autoneg_restart
  ) else $error("negotiation restart without speed field");

  chk_enc_release: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_usb_video && s_q.fields[fld_reset])
    |=> video_pins.video_enc_reset_n
  ) else $error("encoder reset not released");

  chk_xcvr_release: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && s_q.fields[fld_reset])
    |=> eth_pins.fast_eth_xcvr_reset_n
  ) else $error("transceiver reset not released");

  chk_xcvr_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth && !s_q.fields[fld_reset])
    |=> !eth_pins.fast_eth_xcvr_reset_n
  ) else $error("transceiver reset not held");

  chk_usb_eth_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_usb_video)
    |=> (eth_pins == '0)
  ) else $error("transceiver pins moved on video board");

  chk_eth_vid_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_fast_eth)
    |=> (video_pins == '0)
  ) else $error("video pins moved on transceiver board");

  chk_vbus_eth_off: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind != board_usb_video)
    |=> !video_pins.usb_bus_power_on
  ) else $error("bus power without usb board");

  chk_led_dark: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_usb_video && s_q.fields[fld_video_led])
    |=> !video_pins.video_led_on
  ) else $error("video led not dark");

  chk_led_lit: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_usb_video && !s_q.fields[fld_video_led])
    |=> video_pins.video_led_on
  ) else $error("video led not lit");

  chk_clk_gen_off: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind == board_usb_video && !s_q.fields[fld_clk_cfg])
    |=> !video_pins.video_clock_gen_enable
  ) else $error("clock generator left on");

  // field 7 is storage only: with the others steady no pin but autoneg_restart may move
  chk_spare_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    ($stable(s_q.kind) && $stable(s_q.fields[fld_hi:fld_video_led]) &&
      $stable(s_q.fields[fld_pwr_duplex:fld_lo]))
    |=> ($stable(video_pins) && $stable(eth_pins[4:1]))
  ) else $error("spare field moved a pin");

  chk_pins_other: assert property (
    @(posedge clk) disable iff (!resetn)
    (s_q.kind != board_usb_video && s_q.kind != board_fast_eth)
    |=> (video_pins == '0 && eth_pins == '0)
  ) else $error("pins moved without a supported board");

endmodule : board_control_four

//--- rtl/board_ctrl_pkg.sv
// board control register four, fields 5 to 10: constants and carrier types
// assumes a single 100 MHz clock domain and an AHB-Lite register bus
package board_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] board_control_four_off = 8'h10;
  localparam logic [7:0] board_mode_off = 8'h14;

  // ----------------------------------------------------------------
  // field positions in board_control_four
  // ----------------------------------------------------------------
  localparam int fld_speed = 5;
  localparam int fld_pwr_duplex = 6;
  localparam int fld_spare = 7;
  localparam int fld_video_led = 8;
  localparam int fld_clk_cfg = 9;
  localparam int fld_reset = 10;
  localparam int fld_lo = 5;
  localparam int fld_hi = 10;

  // ----------------------------------------------------------------
  // power-on defaults, bits 10 down to 5
  // ----------------------------------------------------------------
  localparam logic [5:0] board_control_four_rst = 6'h3B;

  // fitted daughter board, chosen by software in board_mode
  typedef enum logic [1:0] {
    board_none,
    board_usb_video,
    board_fast_eth
  } board_kind_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  typedef struct packed {
    logic usb_bus_power_on;
    logic video_led_on;
    logic video_clock_gen_enable;
    logic video_enc_reset_n;
  } video_pins_t;

  typedef struct packed {
    logic fast_eth_speed_100;
    logic fast_eth_full_duplex;
    logic fast_eth_config_one;
    logic fast_eth_xcvr_reset_n;
    logic autoneg_restart;
  } eth_pins_t;

endpackage : board_ctrl_pkg

//--- rtl/board_pin_map.sv
// routes stored register fields onto the daughter board pins
// assumes fields and board kind come from registers on the same clock
`timescale 1ns/1ns
module board_pin_map
  import board_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // stored fields
  input wire logic [fld_hi:fld_lo] fields,
  input wire board_kind_t kind,
  // board pins
  output video_pins_t video_pins,
  output eth_pins_t eth_pins
);

  typedef struct packed {
    video_pins_t vid;
    eth_pins_t eth;
    logic speed_prev;
  } map_state_t;

  map_state_t s_q;
  map_state_t s_d;

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  // idle boards see the safe level: power off, led dark, clock off, reset held
  always_comb begin
    s_d = s_q;
    s_d.speed_prev = fields[fld_speed];
    s_d.vid = '{1'b0, 1'b0, 1'b0, 1'b0};
    s_d.eth = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    if (kind == board_usb_video) begin
      s_d.vid.usb_bus_power_on = !fields[fld_pwr_duplex];
      s_d.vid.video_led_on = !fields[fld_video_led];
      s_d.vid.video_clock_gen_enable = fields[fld_clk_cfg];
      s_d.vid.video_enc_reset_n = fields[fld_reset];
    end
    if (kind == board_fast_eth) begin
      s_d.eth.fast_eth_speed_100 = fields[fld_speed];
      // same pin serves as advertisement or forced duplex in the transceiver
      s_d.eth.fast_eth_full_duplex = fields[fld_pwr_duplex];
      s_d.eth.fast_eth_config_one = fields[fld_clk_cfg];
      s_d.eth.fast_eth_xcvr_reset_n = fields[fld_reset];
      s_d.eth.autoneg_restart = fields[fld_speed] && !s_q.speed_prev;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{'{1'b0, 1'b0, 1'b0, 1'b0}, '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign video_pins = s_q.vid;
  assign eth_pins = s_q.eth;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_usb_power: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_usb_video && !fields[fld_pwr_duplex]) |=> video_pins.usb_bus_power_on)
    else $error("usb power not applied");
  chk_usb_off: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_usb_video && fields[fld_pwr_duplex]) |=> !video_pins.usb_bus_power_on)
    else $error("usb power not removed");
  chk_eth_duplex: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_fast_eth) |=> eth_pins.fast_eth_full_duplex == $past(fields[fld_pwr_duplex]))
    else $error("duplex pin wrong");
  chk_video_led: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_usb_video) |=> video_pins.video_led_on == !$past(fields[fld_video_led]))
    else $error("video led wrong");
  chk_clk_gen: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_usb_video) |=> video_pins.video_clock_gen_enable == $past(fields[fld_clk_cfg]))
    else $error("clock generator enable wrong");
  chk_eth_cfg: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_fast_eth) |=> eth_pins.fast_eth_config_one == $past(fields[fld_clk_cfg]))
    else $error("config pin wrong");
  chk_reset_pin: assert property (@(posedge clk) disable iff (!resetn)
    (!fields[fld_reset]) |=> !video_pins.video_enc_reset_n && !eth_pins.fast_eth_xcvr_reset_n)
    else $error("reset not held");
  chk_no_board: assert property (@(posedge clk) disable iff (!resetn)
    (kind == board_none) |=> (video_pins == '0 && eth_pins == '0))
    else $error("idle board pins moved");

endmodule : board_pin_map
